// ---- hw/cmp_max_pkg.sv ----
// Package of opcodes, widths, latencies and carrier types for the unit
package cmp_max_pkg;
	localparam int DATA_W = 32;
	localparam int IMM_W = 7;
	localparam int OPC_W = 8;
	localparam int GUARD_BIT = 0;
	localparam int ALU_LATENCY = 1;
	localparam int DSP_LATENCY = 2;
	localparam logic [OPC_W-1:0] OPC_LE = 8'h0e;
	localparam logic [OPC_W-1:0] OPC_LE_IMM = 8'h2a;
	localparam logic [OPC_W-1:0] OPC_LT = 8'h0f;
	localparam logic [OPC_W-1:0] OPC_LT_IMM = 8'h02;
	localparam logic [OPC_W-1:0] OPC_MAX = 8'h18;
	localparam logic [DATA_W-1:0] RESULT_TRUE = 32'h00000001;
	localparam logic [DATA_W-1:0] RESULT_FALSE = 32'h00000000;
	localparam logic [DATA_W-1:0] RESET_DATA = 32'h00000000;

	typedef struct packed {
		logic valid;
		logic [OPC_W-1:0] opcode;
		logic [DATA_W-1:0] first_source_reg;
		logic [DATA_W-1:0] second_source_reg;
		logic [IMM_W-1:0] modifier;
		logic guard_present;
		logic [DATA_W-1:0] guard_reg;
	} issue_type;

	typedef struct packed {
		logic write;
		logic [DATA_W-1:0] dest_reg;
	} wb_type;
endpackage : cmp_max_pkg

// ---- hw/signed_lt_core.sv ----
// Signed less-than and equality core shared by all operations
module signed_lt_core (
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	output logic lt,
	output logic eq
);
	always_comb begin
		lt = $signed(a) < $signed(b);
		eq = a == b;
	end
endmodule : signed_lt_core

// ---- hw/signed_compare_max_unit.sv ----
// Guarded signed compare and maximum datapath slice
// Function
// RL1 - Opcode 14 writes 1 when first <= second, else 0; one-cycle ALU.
// RL2 - Scheduler turns less-equal into greater-equal with operands swapped.
// RL3 - Opcode 42 writes 1 when first <= signed 7-bit modifier, else 0.
// RL4 - Opcode 15 writes 1 when first < second, else 0, zero when equal.
// RL5 - Scheduler turns less-than into greater-than with operands swapped.
// RL6 - Opcode 2 writes 1 when first < signed 7-bit modifier, else 0.
// RL7 - Opcode 24 writes larger of first and second; two-cycle DSP path.
// RL8 - All operands and modifiers compared as two's-complement signed values.
// RL9 - With a guard present, write only when its low bit is 1.
// RL10 - Data is 32 bits; compare results are exactly one or zero.
module signed_compare_max_unit (
	input wire logic sys_clk,
	input wire logic rst,
	input cmp_max_pkg::issue_type issue,
	output cmp_max_pkg::wb_type alu_wb,
	output cmp_max_pkg::wb_type dsp_wb
);
	import cmp_max_pkg::*;

	typedef enum logic [5:0] {
		OP_NONE = 6'b000001,
		OP_LE = 6'b000010,
		OP_LE_IMM = 6'b000100,
		OP_LT = 6'b001000,
		OP_LT_IMM = 6'b010000,
		OP_MAX = 6'b100000
	} op_type;

	function automatic op_type decode_op(input logic [OPC_W-1:0] opc);
		case (opc)
			OPC_LE: decode_op = OP_LE;
			OPC_LE_IMM: decode_op = OP_LE_IMM;
			OPC_LT: decode_op = OP_LT;
			OPC_LT_IMM: decode_op = OP_LT_IMM;
			OPC_MAX: decode_op = OP_MAX;
			default: decode_op = OP_NONE;
		endcase
	endfunction : decode_op

	function automatic logic guard_ok(input issue_type i);
		guard_ok = !i.guard_present || i.guard_reg[GUARD_BIT];
	endfunction : guard_ok

	op_type op;
	logic [DATA_W-1:0] imm_ext;
	logic [DATA_W-1:0] rhs;
	logic lt;
	logic eq;
	logic max_take;

	wb_type alu_q, alu_d;
	wb_type dsp1_q, dsp1_d;
	wb_type dsp2_q, dsp2_d;

	always_comb begin
		op = decode_op(issue.opcode);
		// Modifier is sign-extended so -64 compares below any small value
		imm_ext = {{(DATA_W-IMM_W){issue.modifier[IMM_W-1]}},
			issue.modifier}; // RL8
		rhs = (op == OP_LE_IMM || op == OP_LT_IMM) ?
			imm_ext : issue.second_source_reg;
	end

	signed_lt_core u_core (
		.a(issue.first_source_reg),
		.b(rhs),
		.lt(lt),
		.eq(eq)
	);

	// General ALU path: one cycle from issue to write-back
	always_comb begin
		alu_d.write = 1'b0;
		alu_d.dest_reg = alu_q.dest_reg;
		if (issue.valid && guard_ok(issue)) begin // RL9
			unique case (op)
				OP_LE, OP_LE_IMM: begin // RL1 RL3
					alu_d.write = 1'b1;
					alu_d.dest_reg = (lt || eq) ? RESULT_TRUE : RESULT_FALSE; // RL10
				end
				OP_LT, OP_LT_IMM: begin // RL4 RL6
					alu_d.write = 1'b1;
					alu_d.dest_reg = lt ? RESULT_TRUE : RESULT_FALSE; // RL10
				end
				OP_MAX, OP_NONE: begin
					alu_d.write = 1'b0;
				end
			endcase
		end
	end

	// DSP path is two stages; compare in stage one, select held to stage two
	always_comb begin
		max_take = issue.valid && guard_ok(issue) && op == OP_MAX; // RL7 RL9
		dsp1_d.write = max_take;
		// First wins only when strictly greater; on equal either is the same
		dsp1_d.dest_reg = (!lt && !eq) ? issue.first_source_reg
			: issue.second_source_reg; // RL7 RL8
		dsp2_d = dsp1_q;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alu_q <= '{write: 1'b0, dest_reg: RESET_DATA};
			dsp1_q <= '{write: 1'b0, dest_reg: RESET_DATA};
			dsp2_q <= '{write: 1'b0, dest_reg: RESET_DATA};
		end else begin
			alu_q <= alu_d;
			dsp1_q <= dsp1_d;
			dsp2_q <= dsp2_d;
		end
	end

	assign alu_wb = alu_q;
	assign dsp_wb = dsp2_q;

	// Assertions
	sequence s_cmp_issue;
		issue.valid && guard_ok(issue) &&
			(op == OP_LE || op == OP_LE_IMM || op == OP_LT || op == OP_LT_IMM);
	endsequence

	property p_le_result;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LE |=>
			alu_wb.write && alu_wb.dest_reg ==
			(($signed($past(issue.first_source_reg)) <=
			$signed($past(issue.second_source_reg))) ? 32'h1 : 32'h0);
	endproperty
	a_le_result: assert property (p_le_result) // RL1
		else $error("less-equal result wrong");

	property p_le_imm_result;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LE_IMM |=>
			alu_wb.dest_reg[0] == ($signed($past(issue.first_source_reg)) <=
			$signed($past(issue.modifier)));
	endproperty
	a_le_imm_result: assert property (p_le_imm_result) // RL3
		else $error("less-equal immediate result wrong");

	property p_lt_equal_zero;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LT &&
			issue.first_source_reg == issue.second_source_reg |=>
			alu_wb.write && alu_wb.dest_reg == 32'h0;
	endproperty
	a_lt_equal_zero: assert property (p_lt_equal_zero) // RL4
		else $error("less-than on equal operands not zero");

	property p_lt_imm_result;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LT_IMM |=>
			alu_wb.dest_reg[0] == ($signed($past(issue.first_source_reg)) <
			$signed($past(issue.modifier)));
	endproperty
	a_lt_imm_result: assert property (p_lt_imm_result) // RL6
		else $error("less-than immediate result wrong");

	// A max one cycle earlier would answer in the quiet cycle, so exclude it
	sequence s_max_alone;
		!max_take ##1 max_take;
	endsequence

	property p_max_latency;
		@(posedge sys_clk) disable iff (rst)
		s_max_alone |=>
			!dsp_wb.write ##1 dsp_wb.write && dsp_wb.dest_reg ==
			(($signed($past(issue.first_source_reg, 2)) >
			$signed($past(issue.second_source_reg, 2))) ?
			$past(issue.first_source_reg, 2) : $past(issue.second_source_reg, 2));
	endproperty
	a_max_latency: assert property (p_max_latency) // RL7
		else $error("maximum result or latency wrong");

	property p_signed_order;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LT &&
			issue.first_source_reg[31] && !issue.second_source_reg[31] |=>
			alu_wb.dest_reg == 32'h1;
	endproperty
	a_signed_order: assert property (p_signed_order) // RL8
		else $error("negative operand not treated as smaller");

	property p_guard_false;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && issue.guard_present && !issue.guard_reg[0] |=>
			!alu_wb.write ##1 !dsp_wb.write;
	endproperty
	a_guard_false: assert property (p_guard_false) // RL9
		else $error("write despite false guard");

	property p_result_width;
		@(posedge sys_clk) disable iff (rst)
		s_cmp_issue |=> alu_wb.write && alu_wb.dest_reg[31:1] == 31'h0;
	endproperty
	a_result_width: assert property (p_result_width) // RL10
		else $error("compare result not zero-extended");

	property p_lt_result;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && guard_ok(issue) && op == OP_LT |=>
			alu_wb.write && alu_wb.dest_reg ==
			(($signed($past(issue.first_source_reg)) <
			$signed($past(issue.second_source_reg))) ? 32'h1 : 32'h0);
	endproperty
	a_lt_result: assert property (p_lt_result) // RL4
		else $error("less-than result wrong");

	property p_guard_hold;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && issue.guard_present && !issue.guard_reg[GUARD_BIT] |=>
			alu_wb.dest_reg == $past(alu_wb.dest_reg);
	endproperty
	a_guard_hold: assert property (p_guard_hold) // RL9
		else $error("destination changed despite false guard");

	property p_reset_quiet;
		@(posedge sys_clk)
		rst |=> !alu_wb.write && !dsp_wb.write &&
			alu_wb.dest_reg == RESET_DATA;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) // RL10
		else $error("outputs not cleared by reset");

	property p_unknown_refused;
		@(posedge sys_clk) disable iff (rst)
		issue.valid && op == OP_NONE |=> !alu_wb.write ##1 !dsp_wb.write;
	endproperty
	a_unknown_refused: assert property (p_unknown_refused) // RL7
		else $error("write for an unknown opcode");
endmodule : signed_compare_max_unit

// ---- test/issue_model.sv ----
// Issue-side model that presents one operation to the unit at a time
module issue_model
	import cmp_max_pkg::*;
(
	input wire logic sys_clk,
	output issue_type issue
);
	timeunit 1ns;
	timeprecision 1ps;
	initial issue = '0;
	// Operands go out already in less-than form, so no swap is done here
	task automatic send(input logic [7:0] opc, input logic [31:0] a, b,
		input logic [6:0] m, input logic [1:0] g);
		@(negedge sys_clk);
		issue = '{1'b1, opc, a, b, m, g[1], {31'h7fffffff, g[0]}};
		@(negedge sys_clk);
		// A released bus shows garbled operands, never the old ones
		issue = {1'b0, ~issue[$bits(issue_type)-2:0]};
	endtask : send
endmodule : issue_model

// ---- test/testbench.sv ----
// Self-checking bench for the signed compare and maximum unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cmp_max_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	issue_type issue;
	wb_type alu_wb;
	wb_type dsp_wb;
	int errors = 0;
	int checked = 0;
	always #5 sys_clk = ~sys_clk;
	issue_model u_issue_model (.sys_clk(sys_clk), .issue(issue));
	signed_compare_max_unit u_signed_compare_max_unit (.sys_clk(sys_clk),
		.rst(rst), .issue(issue), .alu_wb(alu_wb), .dsp_wb(dsp_wb));
	task automatic check(input string what, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	// g[1] guard supplied, g[0] its low bit; exp is the old value if no write
	task automatic alu(input logic [7:0] opc, input logic [31:0] a, b,
		input logic [6:0] m, input logic [1:0] g, input logic [31:0] exp);
		u_issue_model.send(opc, a, b, m, g);
		check("alu write", {31'h0, !g[1] || g[0]}, {31'h0, alu_wb.write});
		check("alu dest", exp, alu_wb.dest_reg);
	endtask : alu
	task automatic dsp(input logic [31:0] a, b, input logic [1:0] g,
		input logic [31:0] exp);
		u_issue_model.send(OPC_MAX, a, b, 7'h00, g);
		check("dsp early", 32'h0, {31'h0, dsp_wb.write});
		@(negedge sys_clk);
		check("dsp write", {31'h0, !g[1] || g[0]}, {31'h0, dsp_wb.write});
		if (!g[1] || g[0]) check("dsp dest", exp, dsp_wb.dest_reg);
	endtask : dsp
	task automatic t_le();
		alu(OPC_LE, 32'h3, 32'h4, 7'h00, 2'b00, RESULT_TRUE);
		alu(OPC_LE, 32'h1000, 32'h100, 7'h00, 2'b11, RESULT_FALSE);
		alu(OPC_LE, 32'h80000000, 32'h4, 7'h00, 2'b00, RESULT_TRUE);
		alu(OPC_LE, 32'h100, 32'h3, 7'h00, 2'b10, RESULT_TRUE);
		alu(OPC_LE, 32'h80000000, 32'h80000000, 7'h00, 2'b00, 32'h1);
		$display("test le done");
	endtask : t_le
	task automatic t_lt();
		alu(OPC_LT, 32'h3, 32'h4, 7'h00, 2'b11, RESULT_TRUE);
		alu(OPC_LT, 32'h100, 32'h3, 7'h00, 2'b10, RESULT_TRUE);
		alu(OPC_LT, 32'h80000000, 32'h80000000, 7'h00, 2'b00, 32'h0);
		alu(OPC_LT, 32'h80000000, 32'h4, 7'h00, 2'b00, RESULT_TRUE);
		$display("test lt done");
	endtask : t_lt
	task automatic t_imm();
		logic [6:0] m [5] = '{7'h02, 7'h03, 7'h04, 7'h40, 7'h3f};
		logic [31:0] a [5] = '{32'h3, 32'h3, 32'h3, 32'h80000000, 32'h100};
		logic [4:0] le = 5'b01110;
		logic [4:0] lt = 5'b01100;
		for (int i = 0; i < 5; i++) begin
			alu(OPC_LE_IMM, a[i], 32'h0, m[i], 2'b11, {31'h0, le[i]});
			alu(OPC_LT_IMM, a[i], 32'h0, m[i], 2'b00, {31'h0, lt[i]});
		end
		$display("test immediate done");
	endtask : t_imm
	task automatic t_max();
		dsp(32'h2, 32'h1, 2'b00, 32'h2);
		dsp(32'h100, 32'hffffff9c, 2'b11, 32'h100);
		dsp(32'hffffff00, 32'hffffff9c, 2'b00, 32'hffffff9c);
		dsp(32'h100, 32'h2, 2'b10, 32'h0);
		// Neighbouring minimum opcode must be ignored by both paths
		u_issue_model.send(8'h17, 32'h1, 32'h2, 7'h00, 2'b00);
		check("refused alu", 32'h0, {31'h0, alu_wb.write});
		@(negedge sys_clk);
		check("refused dsp", 32'h0, {31'h0, dsp_wb.write});
		$display("test max done");
	endtask : t_max
	// Reset lands while a max is in flight and a compare result is held
	task automatic t_reset();
		alu(OPC_LE, 32'h3, 32'h4, 7'h00, 2'b00, RESULT_TRUE);
		u_issue_model.send(OPC_MAX, 32'h2, 32'h1, 7'h00, 2'b00);
		rst = 1'b1;
		@(negedge sys_clk);
		check("reset dsp write", 32'h0, {31'h0, dsp_wb.write});
		@(negedge sys_clk);
		rst = 1'b0;
		check("reset alu dest", RESET_DATA, alu_wb.dest_reg);
		$display("test reset done");
	endtask : t_reset
	task automatic conclude();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	initial begin
		#20000;
		errors++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		check("reset dest", RESET_DATA, alu_wb.dest_reg);
		t_le();
		t_lt();
		t_imm();
		t_max();
		t_reset();
		conclude();
	end
endmodule : testbench
